// file: pkg/bss_pkg.sv
// Purpose: Shared constants and types for the boot strap sampler.
// Assumes: The core clock runs at 100 MHz.
// Notes:   The strap levels travel together as one packed struct.
package bss_pkg;

	// Core clock period and the capture delay after power-on reset release.
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned CAPTURE_NS_X10 = 15;   // 1.5 us, written in tenths of a microsecond.
	localparam int unsigned CAPTURE_CYCLES = (CAPTURE_NS_X10 * 100) / CLK_PERIOD_NS;

	// Depth of the pin synchroniser chain.
	localparam int unsigned SYNC_STAGES = 3;

	// Strap pin count and field positions in the pin vectors.
	localparam int unsigned STRAP_COUNT   = 3;
	localparam int unsigned POS_BOOT_HOLD = 0;
	localparam int unsigned POS_SPREAD    = 1;
	localparam int unsigned POS_SIX       = 2;

	// Captured strap levels and their reset values.
	typedef struct packed {
		logic six;
		logic spread_spectrum;
		logic boot_hold;
	} bss_strap_type;

	localparam bss_strap_type STRAP_RESET = '{six: 1'b0, spread_spectrum: 1'b0, boot_hold: 1'b0};

	// Sequence of the sampler.
	typedef enum logic [1:0] {
		BSS_IN_RESET = 2'b00,
		BSS_WAITING  = 2'b01,
		BSS_CAPTURED = 2'b10
	} bss_state_type;

endpackage : bss_pkg

// file: hw/bss_top.sv
// Purpose: Captures the board strap pins once after power-on reset rises, decodes them
//          and then hands the pins over to debug output use.
// Assumes: The straps and the power-on reset pin are asynchronous to clk_i.
// Notes:   The output drivers are gated by the raw reset pin so they release at once.
`timescale 1ns/1ns

module bss_top
	import bss_pkg::*;
#(
	parameter int unsigned CAPTURE_CYCLES_P = CAPTURE_CYCLES
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   power_on_reset_n_i,
	input  wire logic [STRAP_COUNT-1:0] strap_i,
	input  wire logic [STRAP_COUNT-1:0] debug_data_i,
	input  wire logic [STRAP_COUNT-1:0] debug_en_i,
	output logic      [STRAP_COUNT-1:0] strap_o,
	output logic      [STRAP_COUNT-1:0] strap_oe_o,
	output logic                        init_start_o,
	output logic                        straps_valid_o,
	output logic                        boot_hold_o,
	output logic                        load_main_o,
	output logic                        spread_use_flash_o,
	output logic                        spread_disable_o,
	output logic                        pullup_strap_six_o
);

	// Pipeline width, counter width and the capture count as the checks see it.
	localparam int unsigned SYNC_W = STRAP_COUNT + 1;
	localparam int unsigned CNT_W  = $clog2(CAPTURE_CYCLES_P + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CAPTURE_CYCLES_P - 1);
	localparam int CHK_CAP = CAPTURE_CYCLES_P;
	localparam int CHK_GAP = CHK_CAP - 1; // Cycles from the end of the quiet pair to the capture.

	// Synchroniser, filter, sequencer and captured-strap state.
	logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync3_reg;
	logic [SYNC_W-1:0] filt_reg, filt_next;
	bss_state_type     state_reg, state_next;
	logic [CNT_W-1:0]  cnt_reg, cnt_next;
	bss_strap_type     cap_reg, cap_next;
	logic              valid_reg, valid_next;
	logic              start_reg, start_next;
	logic              por_filt;
	bss_strap_type     strap_filt;

	// Three-stage synchroniser on the reset pin and the straps; the first stage feeds only the second.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= {power_on_reset_n_i, strap_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// A bit only changes once the second and third stages agree, which rejects a metastable glitch.
	generate
		for (genvar g = 0; g < SYNC_W; g++) begin : g_filt
			always_comb begin
				filt_next[g] = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g] : filt_reg[g];
			end
		end
	endgenerate

	// Filtered levels start low, the same as a power-on reset pin held low at start-up.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			filt_reg <= '0;
		end else begin
			filt_reg <= filt_next;
		end
	end

	assign por_filt   = filt_reg[STRAP_COUNT];
	assign strap_filt = bss_strap_type'(filt_reg[STRAP_COUNT-1:0]);

	// Sequencer: a low reset pin holds everything, its rise starts the delay, expiry captures.
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		cap_next   = cap_reg;
		valid_next = valid_reg;
		start_next = 1'b0;
		if (!por_filt) begin
			state_next = BSS_IN_RESET;
			cnt_next   = '0;
			cap_next   = STRAP_RESET;
			valid_next = 1'b0;
		end else begin
			case (state_reg)
				BSS_IN_RESET: begin
					state_next = BSS_WAITING;
					start_next = 1'b1;
					cnt_next   = '0;
				end
				BSS_WAITING: begin
					if (cnt_reg == CNT_LAST) begin
						cap_next   = strap_filt;
						valid_next = 1'b1;
						state_next = BSS_CAPTURED;
					end else begin
						cnt_next = cnt_reg + CNT_W'(1);
					end
				end
				BSS_CAPTURED: begin
					state_next = BSS_CAPTURED; // Later pin activity is ignored.
				end
				default: begin
					state_next = BSS_IN_RESET;
				end
			endcase
		end
	end

	// Sequencer registers; the core reset returns the block to waiting for a reset pin rise.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= BSS_IN_RESET;
			cnt_reg   <= '0;
			cap_reg   <= STRAP_RESET;
			valid_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			cap_reg   <= cap_next;
			valid_reg <= valid_next;
			start_reg <= start_next;
		end
	end

	// Decoded straps; boot hold and spread spectrum come in both polarities so consumers need no inverter of their own.
	assign boot_hold_o        = cap_reg.boot_hold;
	assign load_main_o        = ~cap_reg.boot_hold;
	assign spread_use_flash_o = cap_reg.spread_spectrum;
	assign spread_disable_o   = ~cap_reg.spread_spectrum;
	assign pullup_strap_six_o = cap_reg.six;
	assign straps_valid_o     = valid_reg;
	assign init_start_o       = start_reg;

	// Pin drivers: the raw reset pin gates the enable so the pins float without a sync delay.
	assign strap_o    = debug_data_i;
	assign strap_oe_o = debug_en_i & {STRAP_COUNT{valid_reg & power_on_reset_n_i}};

	// Every check runs on the core clock and pauses while the core reset is high.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Opening step of a capture attempt: the one-cycle start pulse.
	sequence seq_start;
		init_start_o;
	endsequence

	// Second step: no capture in the first two cycles of the wait.
	sequence seq_wait_quiet;
		!straps_valid_o [*2];
	endsequence

	// Pin drivers stay off in reset and until the strap level has been captured.
	chk_oe_in_reset: assert property (!power_on_reset_n_i |-> strap_oe_o == '0)
		else $error("Strap driver enabled while power-on reset is low.");

	chk_oe_after_capture: assert property ((strap_oe_o != '0) |-> straps_valid_o)
		else $error("Strap driver enabled before the strap was captured.");

	// Capture timing: the strap is taken the set count after the start pulse, never earlier.
	chk_capture_delay: assert property (seq_start |-> seq_wait_quiet ##CHK_GAP
		(straps_valid_o || !por_filt))
		else $error("Strap capture did not follow reset release by the set delay.");

	chk_capture_early: assert property ($rose(straps_valid_o) |->
		$past(init_start_o, CHK_CAP))
		else $error("Strap captured at a different distance from the start pulse.");

	chk_capture_value: assert property ($rose(straps_valid_o) |->
		cap_reg == $past(strap_filt))
		else $error("Captured strap differs from the pin level at the capture instant.");

	// Decode checks: both polarities follow the captured strap.
	chk_boot_decode: assert property (
		boot_hold_o == cap_reg.boot_hold
		&& load_main_o == !boot_hold_o)
		else $error("Boot strap decode is wrong.");

	chk_spread_decode: assert property (
		spread_use_flash_o == cap_reg.spread_spectrum
		&& spread_disable_o == !spread_use_flash_o)
		else $error("Spread spectrum strap decode is wrong.");

	// Start and abort checks: one start pulse per reset pin rise, none without one, and a low reset pin clears the sequence.
	chk_start_pulse: assert property ($rose(por_filt) |=> init_start_o ##1
		(!init_start_o && state_reg == BSS_WAITING))
		else $error("Reset release did not start initialization with one pulse.");

	chk_start_source: assert property (init_start_o |->
		$past(por_filt) && $past(state_reg) == BSS_IN_RESET)
		else $error("Start pulse without a preceding reset pin rise.");

	chk_abort_clears: assert property (!por_filt |=>
		!straps_valid_o && state_reg == BSS_IN_RESET)
		else $error("Low reset pin did not clear the capture sequence.");

	// Hold check: a capture stays frozen until the reset pin goes low again.
	chk_hold_const: assert property (straps_valid_o && por_filt |=>
		$stable(cap_reg) || !por_filt)
		else $error("Captured strap changed before the next reset.");

	// Synchroniser check: a filtered bit moves only after the last two stages agreed on it.
	chk_sync_agree: assert property (((filt_reg ^ $past(filt_reg)) &
		($past(sync2_reg) ^ $past(sync3_reg))) == '0)
		else $error("Filtered pin level changed while the synchroniser stages disagreed.");

endmodule : bss_top

// file: tb/bss_board.sv
// Purpose: Board resistors seen by the strap pins.
// Assumes: Each pin has one pull resistor, level given by pull_up_i.
// Notes:   A pin shows the device level only while its driver is on.
`timescale 1ns/1ns

module bss_board
	import bss_pkg::*;
(
	input  wire logic [STRAP_COUNT-1:0] pull_up_i,
	input  wire logic [STRAP_COUNT-1:0] drive_i,
	input  wire logic [STRAP_COUNT-1:0] drive_en_i,
	output wire logic [STRAP_COUNT-1:0] pin_o
);
	// A released pin settles to its resistor level, never to the old driven value.
	assign pin_o = (drive_en_i & drive_i) | (~drive_en_i & pull_up_i);
endmodule : bss_board

// file: tb/bss_top_test.sv
// Purpose: Self-checking bench for the boot strap sampler.
// Assumes: A short capture count of 4 cycles.
// Notes:   Inputs change by non-blocking assignment at the rising edge.
`timescale 1ns/1ns

module bss_top_test;
	import bss_pkg::*;
	localparam int unsigned CAP = 4;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       por_n = 1'b0;
	logic [2:0] dbg_d = 3'h0;
	logic [2:0] dbg_en = 3'h0;
	logic [2:0] pulls = 3'h0;
	wire  [2:0] pin;
	logic [2:0] s_o, s_oe;
	logic       init_o, valid_o, hold_o, main_o, flash_o, dis_o, six_o;
	int         n_fail = 0;
	int         check_count = 0;

	// The clock toggles every half period.
	always #5 clk_i = ~clk_i;

	bss_board u_board (.pull_up_i(pulls), .drive_i(s_o), .drive_en_i(s_oe), .pin_o(pin));
	bss_top #(.CAPTURE_CYCLES_P(CAP)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.power_on_reset_n_i(por_n), .strap_i(pin), .debug_data_i(dbg_d),
		.debug_en_i(dbg_en), .strap_o(s_o), .strap_oe_o(s_oe), .init_start_o(init_o),
		.straps_valid_o(valid_o), .boot_hold_o(hold_o), .load_main_o(main_o),
		.spread_use_flash_o(flash_o), .spread_disable_o(dis_o), .pullup_strap_six_o(six_o));

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic [2:0] seen, input logic [2:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask : check

	// Bounded wait on init (sel 0) or valid (sel 1); running out counts a mismatch.
	task automatic wait_bit(input int sel, output int n);
		n = 0;
		while (((sel == 0) ? init_o : valid_o) !== 1'b1 && n <= 40) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n > 40) begin
			n_fail++;
			$display("wrong value at %0t: wait on signal %0d timed out", $time, sel);
		end
	endtask : wait_bit

	// Full reset, capture and decode with the given resistor pattern.
	task automatic test_decode(input logic [2:0] pull);
		int n;
		@(posedge clk_i);
		por_n <= 1'b0;
		dbg_en <= 3'h7;
		dbg_d <= ~pull;
		pulls <= pull;
		repeat (8) @(posedge clk_i);
		#1 check(s_oe, 3'h0);
		check({1'b0, valid_o, init_o}, 3'h0);
		@(posedge clk_i);
		por_n <= 1'b1;
		wait_bit(0, n);
		check(s_oe, 3'h0);
		@(posedge clk_i);
		#1 check({2'b00, init_o}, 3'h0);
		wait_bit(1, n);
		check(n[2:0] + 3'h1, 3'(CAP));
		check({six_o, flash_o, hold_o}, pull);
		check({1'b0, dis_o, main_o}, {1'b0, ~pull[1], ~pull[0]});
		check(s_oe, 3'h7);
		check(pin, ~pull);
		@(posedge clk_i);
		dbg_en <= 3'h0;
		pulls <= ~pull;
		repeat (10) @(posedge clk_i);
		#1 check({six_o, flash_o, hold_o}, pull);
		$display("decode test done");
	endtask : test_decode

	// Reset drops while driving, then again during the capture wait.
	task automatic test_abort;
		int n;
		@(posedge clk_i);
		dbg_en <= 3'h7;
		dbg_d <= 3'h2;
		@(posedge clk_i);
		#1 check(pin, 3'h2);
		@(posedge clk_i);
		por_n <= 1'b0;
		#1 check(s_oe, 3'h0);
		check(pin, 3'h5);
		repeat (6) @(posedge clk_i);
		por_n <= 1'b1;
		repeat (3) @(posedge clk_i);
		por_n <= 1'b0;
		wait_bit(0, n);
		repeat (CAP + 10) begin
			@(posedge clk_i);
			#1 check({2'b00, valid_o}, 3'h0);
		end
		@(posedge clk_i);
		por_n <= 1'b1;
		wait_bit(0, n);
		wait_bit(1, n);
		check({2'b00, valid_o}, 3'h1);
		check({six_o, flash_o, hold_o}, 3'h5);
		$display("abort test done");
	endtask : test_abort

	// Core reset in mid-run clears the capture; release with the pin high captures afresh.
	task automatic test_core_reset;
		int n;
		@(posedge clk_i);
		rst_i <= 1'b1;
		pulls <= 3'h2;
		#1 check({1'b0, valid_o, init_o}, 3'h0);
		check(s_oe, 3'h0);
		check(pin, 3'h2);
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_bit(0, n);
		check(s_oe, 3'h0);
		wait_bit(1, n);
		check({six_o, flash_o, hold_o}, 3'h2);
		check(s_oe, 3'h7);
		$display("core reset test done");
	endtask : test_core_reset

	// Main sequence.
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		test_decode(3'h5);
		test_decode(3'h2);
		test_abort();
		test_core_reset();
		close_out();
	end
endmodule : bss_top_test
